// ### rtl/aos_sequencer.sv
// Analog output sequencer: sample store control, pacing, start/stop
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - FIFO appends new, converts oldest first
// - FIFO accepts writes while output runs
// - FIFO overflow flags, output keeps going
// - Ring: writes refused during output
// - Ring outputs in order, wrapping around
// - Repeat count accepted only in ring
// - Endless repeat ends only by stop or error
// - Sample pace: internal divider or pin edge
// - Start and stop conditions set separately
// - Software start begins sampling at once
// - Trigger start waits for chosen edge
// - Clock error halts sampling; overflow does not
// - Count stop ends after set samples
// - Trigger stop: count first, then edge
// - Software stop runs until stop/error
// - Start-met event, none for software start
// - Repeat-end and whole-operation-done events
// - Transfer event: FIFO level or ring count
// - Short sample period: error, event, stop
// - Operating status from start to end
// - Trigger-wait status on each start wait
// - Memory reset clears data and counts
module aos_sequencer
   import aos_pkg::*;
#(
   parameter int MEM_AW = 10
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [REG_W-1:0] i_wr_data,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   output logic [REG_W-1:0] o_rd_data,
   input wire logic i_ext_clk,
   input wire logic i_ext_trig,
   output logic [DATA_W-1:0] o_dac_data,
   output logic o_dac_load,
   output logic o_operating
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_q;
   logic [CNT_W-1:0] div_q;
   logic [CNT_W-1:0] rep_q;
   logic [CNT_W-1:0] scnt_q;
   logic [CNT_W-1:0] thr_q;
   logic [EV_W-1:0] evt_q;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;
   logic [MEM_AW-1:0] wr_ptr_q;
   logic [MEM_AW-1:0] rd_ptr_q;
   logic [MEM_AW:0] fill_q;
   aos_state_t state_q;
   logic [CNT_W-1:0] samp_q;
   logic [CNT_W-1:0] rep_done_q;
   logic [CNT_W-1:0] samp_inc;
   logic [CNT_W-1:0] rep_inc;
   logic [CNT_W-1:0] div_cnt_q;
   logic [GAP_W-1:0] gap_q;
   logic [2:0] clk_sync_q;
   logic [2:0] trig_sync_q;
   logic ndata_q;
   logic clkerr_q;
   logic ovf_q;
   logic load_q;
   logic wr_ctrl, wr_cmd, wr_data, wr_rep, wr_scnt, wr_div, wr_thr;
   logic wr_evt;
   logic cmd_start, cmd_stop, cmd_strst, cmd_memrst;
   logic idle, ring, start_ext, active, int_tick, clk_edge;
   logic tick, clk_err, take, reached, start_edge, stop_edge;
   logic rep_end, more, wr_ok;
   logic [1:0] stop_sel;

   aos_mem_if #(.AW(MEM_AW), .DW(DATA_W)) mbus ();

   aos_sample_mem #(.AW(MEM_AW), .DW(DATA_W)) u_mem (
      .i_ref_clk(i_ref_clk),
      .m(mbus.mem)
   );

   // Edge detect on a synchronised level, polarity selectable
   function automatic logic edge_seen(input logic prev, input logic cur,
                                      input logic fall);
      edge_seen = fall ? (prev & ~cur) : (~prev & cur);
   endfunction

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   assign wr_ctrl = i_wr_stb && (i_addr == OFS_CTRL);
   assign wr_cmd = i_wr_stb && (i_addr == OFS_CMD);
   assign wr_data = i_wr_stb && (i_addr == OFS_DATA);
   assign wr_rep = i_wr_stb && (i_addr == OFS_REPEAT);
   assign wr_scnt = i_wr_stb && (i_addr == OFS_SCOUNT);
   assign wr_div = i_wr_stb && (i_addr == OFS_DIV);
   assign wr_thr = i_wr_stb && (i_addr == OFS_THRESH);
   assign wr_evt = i_wr_stb && (i_addr == OFS_EVENT);
   assign cmd_start = wr_cmd && i_wr_data[CMD_START];
   assign cmd_stop = wr_cmd && i_wr_data[CMD_STOP];
   assign cmd_strst = wr_cmd && i_wr_data[CMD_STRST];
   assign cmd_memrst = wr_cmd && i_wr_data[CMD_MEMRST];

   // Mode decode; start and stop selections are separate fields
   assign ring = ctrl_q[CTRL_RING];
   assign start_ext = ctrl_q[CTRL_STEXT];
   assign stop_sel = ctrl_q[CTRL_SPSEL +: 2];
   assign idle = (state_q == AOS_IDLE);
   assign active = (state_q == AOS_RUN) || (state_q == AOS_WAIT_STOP);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Bit 0 feeds only bit 1; edges are read from bits 1 and 2
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         clk_sync_q <= 3'h0;
         trig_sync_q <= 3'h0;
      end else begin
         clk_sync_q <= {clk_sync_q[1:0], i_ext_clk};
         trig_sync_q <= {trig_sync_q[1:0], i_ext_trig};
      end
   end

   assign clk_edge = edge_seen(clk_sync_q[2], clk_sync_q[1],
                               ctrl_q[CTRL_CLKNEG]);
   assign start_edge = (state_q == AOS_WAIT_START) &&
      edge_seen(trig_sync_q[2], trig_sync_q[1], ctrl_q[CTRL_STNEG]);
   assign stop_edge = (state_q == AOS_WAIT_STOP) &&
      edge_seen(trig_sync_q[2], trig_sync_q[1], ctrl_q[CTRL_SPNEG]);

   // ---------------------------------------------------------------
   // Sample pacing
   // ---------------------------------------------------------------
   // Internal divider; runs only while sampling so the first sample
   // comes out on the first active cycle
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || !active) begin
         div_cnt_q <= 16'h0000;
      end else if (int_tick) begin
         div_cnt_q <= div_q - 16'h0001;
      end else begin
         div_cnt_q <= div_cnt_q - 16'h0001;
      end
   end
   assign int_tick = (div_cnt_q == 16'h0000);

   // Cycles since the last tick, saturating; starts saturated
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || !active) begin
         gap_q <= GAP_MAX;
      end else if (tick) begin
         gap_q <= 8'h01;
      end else if (gap_q != GAP_MAX) begin
         gap_q <= gap_q + 8'h01;
      end
   end

   assign tick = active &&
      (ctrl_q[CTRL_EXTCLK] ? clk_edge : int_tick);
   assign clk_err = tick && (gap_q < GAP_MIN);
   // An empty store simply skips the tick
   assign take = tick && !clk_err && (fill_q != '0);
   assign samp_inc = samp_q + 16'h0001;
   assign rep_inc = rep_done_q + 16'h0001;
   assign reached = take && (samp_inc == scnt_q);
   // Count or trigger-edge stop; software stop never ends by itself
   assign rep_end = ((stop_sel == STOP_COUNT) && reached) ||
                    stop_edge;
   // Repeats only exist in ring organisation
   assign more = ring && (ctrl_q[CTRL_ENDLESS] ||
                          (rep_inc < rep_q));

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Settings change only while idle so a run sees stable values
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ctrl_q <= CTRL_RST;
         div_q <= DIV_RST;
         rep_q <= REPEAT_RST;
         scnt_q <= SCOUNT_RST;
         thr_q <= THRESH_RST;
      end else if (idle) begin
         if (wr_ctrl) begin
            ctrl_q <= i_wr_data[CTRL_W-1:0];
         end
         if (wr_rep && ring) begin
            rep_q <= i_wr_data[CNT_W-1:0];
         end
         if (wr_scnt) begin
            scnt_q <= i_wr_data[CNT_W-1:0];
         end
         if (wr_div) begin
            div_q <= i_wr_data[CNT_W-1:0];
         end
         if (wr_thr) begin
            thr_q <= i_wr_data[CNT_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Stop command and clock error win over every other transition
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         state_q <= AOS_IDLE;
         samp_q <= 16'h0000;
         rep_done_q <= 16'h0000;
      end else if (cmd_stop || clk_err) begin
         state_q <= AOS_IDLE;
      end else begin
         case (state_q)
            AOS_IDLE: begin
               if (cmd_memrst || cmd_start) begin
                  samp_q <= 16'h0000;
                  rep_done_q <= 16'h0000;
               end
               if (cmd_start) begin
                  state_q <= start_ext ? AOS_WAIT_START
                                       : AOS_RUN;
               end
            end
            AOS_WAIT_START: begin
               if (start_edge) begin
                  state_q <= AOS_RUN;
               end
            end
            AOS_RUN, AOS_WAIT_STOP: begin
               if (take) begin
                  samp_q <= samp_inc;
               end
               if (rep_end) begin
                  rep_done_q <= rep_inc;
                  if (more) begin
                     samp_q <= 16'h0000;
                     // With trigger start, each repeat re-enters the trigger wait; otherwise it goes straight back to run
                     state_q <= start_ext ? AOS_WAIT_START
                                          : AOS_RUN;
                  end else begin
                     state_q <= AOS_IDLE;
                  end
               end else if (reached && (stop_sel == STOP_EXT) &&
                            (state_q == AOS_RUN)) begin
                  state_q <= AOS_WAIT_STOP;
               end
            end
            default: begin
               state_q <= AOS_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Sample store pointers
   // ---------------------------------------------------------------
   // Ring writes only while idle; FIFO writes at any time
   assign wr_ok = wr_data && !fill_q[MEM_AW] &&
                  (!ring || idle);

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q <= '0;
      end else if (cmd_memrst && idle) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q <= '0;
      end else begin
         if (wr_ok) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (cmd_start && idle && ring) begin
            rd_ptr_q <= '0;
         end else if (take && ring) begin
            // Ring wraps at the loaded pattern length
            rd_ptr_q <= ({1'b0, rd_ptr_q} + 1'b1 == fill_q) ? '0
                        : rd_ptr_q + 1'b1;
         end else if (take) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         // Ring keeps its samples; FIFO frees each one it converts
         fill_q <= fill_q + {{MEM_AW{1'b0}}, wr_ok} -
                   {{MEM_AW{1'b0}}, take && !ring};
      end
   end

   assign mbus.we = wr_ok;
   assign mbus.waddr = wr_ptr_q;
   assign mbus.wdata = i_wr_data[DATA_W-1:0];
   assign mbus.re = take;
   assign mbus.raddr = rd_ptr_q;

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   // Setting terms come last so a set beats a clear in one cycle
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ndata_q <= 1'b0;
         clkerr_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (cmd_memrst && idle) begin
            ndata_q <= 1'b0;
            ovf_q <= 1'b0;
         end
         if (cmd_strst) begin
            clkerr_q <= 1'b0;
         end
         if (reached) begin
            ndata_q <= 1'b1;
         end
         if (clk_err) begin
            clkerr_q <= 1'b1;
         end
         // Overflow is flagged only; output does not stop for it
         if (wr_data && fill_q[MEM_AW]) begin
            ovf_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Events
   // ---------------------------------------------------------------
   always_comb begin
      ev_set = '0;
      // Software start never reaches the trigger wait, so no event
      ev_set[EV_START] = start_edge;
      ev_set[EV_REPEND] = rep_end && !cmd_stop;
      ev_set[EV_DONE] = rep_end && !more && !cmd_stop;
      ev_set[EV_NOUT] = reached;
      ev_set[EV_XFER] = take && (ring ? (samp_inc == thr_q)
                         : (CNT_W'(fill_q) - 16'h0001 < thr_q));
      ev_set[EV_CLKERR] = clk_err;
      ev_clr = wr_evt ? i_wr_data[EV_W-1:0] : '0;
   end

   // Sticky; software writes ones to clear, a new set wins
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         evt_q <= '0;
      end else begin
         evt_q <= (evt_q & ~ev_clr) | ev_set;
      end
   end

   // ---------------------------------------------------------------
   // Converter output
   // ---------------------------------------------------------------
   // Memory read takes a cycle, so the load pulse trails the take
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         load_q <= 1'b0;
         o_dac_load <= 1'b0;
         o_dac_data <= DAC_RST;
         o_operating <= 1'b0;
      end else begin
         load_q <= take;
         o_dac_load <= load_q;
         if (load_q) begin
            o_dac_data <= mbus.rdata;
         end
         o_operating <= !idle;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Data stand one cycle after the strobe, zero at all other times
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || !i_rd_stb) begin
         o_rd_data <= '0;
      end else begin
         case (i_addr)
            OFS_CTRL: o_rd_data <= REG_W'(ctrl_q);
            OFS_REPEAT: o_rd_data <= REG_W'(rep_q);
            OFS_SCOUNT: o_rd_data <= REG_W'(scnt_q);
            OFS_DIV: o_rd_data <= REG_W'(div_q);
            OFS_THRESH: o_rd_data <= REG_W'(thr_q);
            OFS_STATUS: o_rd_data <= REG_W'({ovf_q, clkerr_q, ndata_q,
               state_q == AOS_WAIT_START,
               !idle});
            OFS_EVENT: o_rd_data <= REG_W'(evt_q);
            OFS_SAMPLES: o_rd_data <= REG_W'(samp_q);
            OFS_REPDONE: o_rd_data <= REG_W'(rep_done_q);
            OFS_FILL: o_rd_data <= REG_W'(fill_q);
            default: o_rd_data <= '0;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### shared/aos_pkg.sv
// Shared constants and types for the analog output sequencer
package aos_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int REG_W = 32;
   localparam int DATA_W = 16;
   localparam int CNT_W = 16;
   localparam int CTRL_W = 9;
   localparam int CMD_W = 4;
   localparam int EV_W = 6;
   localparam int GAP_W = 8;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DATA = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_REPEAT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SCOUNT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DIV = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_EVENT = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_SAMPLES = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_REPDONE = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_FILL = 8'h2C;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_RING = 0;
   localparam int CTRL_EXTCLK = 1;
   localparam int CTRL_CLKNEG = 2;
   localparam int CTRL_STEXT = 3;
   localparam int CTRL_STNEG = 4;
   localparam int CTRL_SPSEL = 5;
   localparam int CTRL_SPNEG = 7;
   localparam int CTRL_ENDLESS = 8;

   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_STRST = 2;
   localparam int CMD_MEMRST = 3;

   localparam int ST_BUSY = 0;
   localparam int ST_TRIGWAIT = 1;
   localparam int ST_NDATA = 2;
   localparam int ST_CLKERR = 3;
   localparam int ST_OVF = 4;

   localparam int EV_START = 0;
   localparam int EV_REPEND = 1;
   localparam int EV_DONE = 2;
   localparam int EV_NOUT = 3;
   localparam int EV_XFER = 4;
   localparam int EV_CLKERR = 5;

   // Stop condition encodings
   localparam logic [1:0] STOP_COUNT = 2'h0;
   localparam logic [1:0] STOP_EXT = 2'h1;
   localparam logic [1:0] STOP_SW = 2'h2;

   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
   localparam logic [CNT_W-1:0] DIV_RST = 16'h0014;
   localparam logic [CNT_W-1:0] SCOUNT_RST = 16'h0100;
   localparam logic [CNT_W-1:0] THRESH_RST = 16'h0010;
   localparam logic [CNT_W-1:0] REPEAT_RST = 16'h0001;
   localparam logic [DATA_W-1:0] DAC_RST = 16'h8000;
   localparam int REF_CLK_MHZ = 20;
   localparam int SAMPLE_MIN_NS = 200;
   localparam int SAMPLE_MIN_CYC =
      (SAMPLE_MIN_NS * REF_CLK_MHZ + 999) / 1000;
   localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(SAMPLE_MIN_CYC);
   localparam logic [GAP_W-1:0] GAP_MAX = 8'hFF;

   typedef enum logic [1:0] {
      AOS_IDLE,
      AOS_WAIT_START,
      AOS_RUN,
      AOS_WAIT_STOP
   } aos_state_t;

endpackage

// ### shared/aos_mem_if.sv
// Port bundle between sequencer and sample memory
`timescale 1ns/10ps
`default_nettype none
interface aos_mem_if #(
   parameter int AW = 10,
   parameter int DW = 16
);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic re;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;

   modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

// ### rtl/aos_sample_mem.sv
// Sample store: one write port, one registered read port
`timescale 1ns/10ps
`default_nettype none
module aos_sample_mem #(
   parameter int AW = 10,
   parameter int DW = 16
) (
   input wire logic i_ref_clk,
   aos_mem_if.mem m
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   // Write port
   always_ff @(posedge i_ref_clk) begin
      if (m.we) begin
         store[m.waddr] <= m.wdata;
      end
   end

   // Read data always leaves from a register
   always_ff @(posedge i_ref_clk) begin
      if (m.re) begin
         m.rdata <= store[m.raddr];
      end
   end
endmodule
`default_nettype wire

// ### verif/aos_far_end.sv
// Far-side model: sampling clock and trigger pins
`timescale 1ns/10ps
`default_nettype none
module aos_far_end (
   input wire logic i_clk,
   output var logic o_ext_clk,
   output var logic o_ext_trig
);
   // Pins rest low between bursts
   initial begin
      o_ext_clk = 1'b0;
      o_ext_trig = 1'b0;
   end
   // One-cycle clock edge; gap sets the period
   task automatic pulse_clk(input int gap);
      o_ext_clk <= 1'b1;
      @(posedge i_clk);
      o_ext_clk <= 1'b0;
      repeat (gap - 1) @(posedge i_clk);
   endtask
   // Held long enough that the synchroniser cannot miss it
   task automatic pulse_trig();
      o_ext_trig <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ext_trig <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### verif/aos_seq_chk.sv
// Port-level assertions for the sequencer
`timescale 1ns/10ps
`default_nettype none
module aos_seq_chk
   import aos_pkg::*;
#(
   parameter int MEM_AW = 10
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [REG_W-1:0] i_wr_data,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   input wire logic [REG_W-1:0] o_rd_data,
   input wire logic i_ext_clk,
   input wire logic i_ext_trig,
   input wire logic [DATA_W-1:0] o_dac_data,
   input wire logic o_dac_load,
   input wire logic o_operating
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   logic [CTRL_W-1:0] ctrl_q;
   logic [3:0] eg_q;
   // Control shadow; the block only takes it while idle
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ctrl_q <= CTRL_RST;
      end else if (i_wr_stb && i_addr == OFS_CTRL && !o_operating) begin
         ctrl_q <= i_wr_data[CTRL_W-1:0];
      end
   end
   // Cycles since the last sampling pin edge, saturating
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || $rose(i_ext_clk)) begin
         eg_q <= 4'h0;
      end else if (eg_q != 4'hF) begin
         eg_q <= eg_q + 4'h1;
      end
   end
   sequence s_start;
      i_wr_stb && i_addr == OFS_CMD && i_wr_data[CMD_START] && !o_operating;
   endsequence
   sequence s_stop;
      i_wr_stb && i_addr == OFS_CMD && i_wr_data[CMD_STOP] && o_operating;
   endsequence
   sequence s_close;
      $rose(i_ext_clk) && eg_q < 4'h3 && o_operating
         && ctrl_q[CTRL_EXTCLK] && !ctrl_q[CTRL_CLKNEG];
   endsequence
   AST_SW_START: assert property (
      s_start ##0 !ctrl_q[CTRL_STEXT] |-> ##2 o_operating)
      else $error("operating late after software start");
   AST_SW_FIRST: assert property (
      s_start ##0 !ctrl_q[CTRL_STEXT] && !ctrl_q[CTRL_EXTCLK]
      |-> ##1 !o_dac_load ##1 !o_dac_load ##1 o_dac_load)
      else $error("first internal sample not on time");
   AST_TRIG_WAIT: assert property (
      s_start ##0 ctrl_q[CTRL_STEXT] ##1 (!i_ext_trig)[*6]
      |-> o_operating && !o_dac_load)
      else $error("output began before the trigger");
   AST_STOP: assert property (
      s_stop |-> ##[1:3] !o_operating)
      else $error("stop command did not end operation");
   AST_DATA_HOLD: assert property (
      !o_dac_load |-> $stable(o_dac_data))
      else $error("converter data moved without a load");
   AST_LOAD_GAP: assert property (
      o_dac_load |=> (!o_dac_load)[*2])
      else $error("loads closer than the minimum period");
   AST_IDLE_QUIET: assert property (
      (!o_operating)[*2] |-> !o_dac_load)
      else $error("load while not operating");
   AST_ERR_STOP: assert property (
      s_close |-> ##[1:8] !o_operating)
      else $error("short sampling period did not stop output");
endmodule
bind aos_sequencer aos_seq_chk #(.MEM_AW(MEM_AW)) u_chk (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
   .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
   .o_rd_data(o_rd_data), .i_ext_clk(i_ext_clk), .i_ext_trig(i_ext_trig),
   .o_dac_data(o_dac_data), .o_dac_load(o_dac_load),
   .o_operating(o_operating));
`default_nettype wire

// ### verif/tb_aos_sequencer.sv
// Self-checking bench for the analog output sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_aos_sequencer
   import aos_pkg::*;
;
   logic i_ref_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_wr_stb = 1'b0;
   logic i_rd_stb = 1'b0;
   logic rd_q = 1'b0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [REG_W-1:0] i_wr_data = '0;
   logic [REG_W-1:0] o_rd_data;
   logic [DATA_W-1:0] o_dac_data;
   logic [DATA_W-1:0] smp;
   logic [DATA_W-1:0] r[3];
   logic o_dac_load, o_operating, ext_clk, ext_trig;
   logic [REG_W-1:0] exp_rd[$];
   logic [DATA_W-1:0] exp_dac[$];
   int errors = 0;
   int total_checks = 0;
   int seed = 32'hCB447597;
   always #25 i_ref_clk = ~i_ref_clk;
   aos_sequencer #(.MEM_AW(10)) DUT (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
      .o_rd_data(o_rd_data), .i_ext_clk(ext_clk), .i_ext_trig(ext_trig),
      .o_dac_data(o_dac_data), .o_dac_load(o_dac_load),
      .o_operating(o_operating));
   aos_far_end far (.i_clk(i_ref_clk), .o_ext_clk(ext_clk),
      .o_ext_trig(ext_trig));
   task automatic check(input logic [REG_W-1:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Strobes stay up between back-to-back accesses; cyc drops them
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      i_wr_stb <= 1'b1;
      i_rd_stb <= 1'b0;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
      exp_rd.push_back(e);
      i_rd_stb <= 1'b1;
      i_wr_stb <= 1'b0;
      i_addr <= a;
      @(posedge i_ref_clk);
   endtask
   task automatic cyc(input int n);
      i_wr_stb <= 1'b0;
      i_rd_stb <= 1'b0;
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic wait_idle();
      int k;
      cyc(0);
      for (k = 0; k < 3000; k++) begin
         @(negedge i_ref_clk);
         if (!o_operating) break;
      end
      if (k == 3000) begin
         errors++;
         report_and_stop();
      end
      @(posedge i_ref_clk);
   endtask
   task automatic load(input int n);
      for (int i = 0; i < n; i++) begin
         smp = 16'($random(seed));
         exp_dac.push_back(smp);
         wr(OFS_DATA, {16'h0000, smp});
      end
   endtask
   // Results are matched against the oldest note
   always @(posedge i_ref_clk) rd_q <= i_rd_stb;
   always @(negedge i_ref_clk) begin
      if (rd_q) check(o_rd_data, exp_rd.pop_front());
      if (o_dac_load) check(32'(o_dac_data), 32'(exp_dac.pop_front()));
   end
   initial begin
      repeat (4) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      rd(OFS_CTRL, 32'(CTRL_RST));
      rd(OFS_REPEAT, 32'(REPEAT_RST));
      rd(OFS_SCOUNT, 32'(SCOUNT_RST));
      rd(OFS_DIV, 32'(DIV_RST));
      rd(OFS_THRESH, 32'(THRESH_RST));
      rd(8'h3C, 32'h0);
      // Ring, count stop, two passes of three samples
      wr(OFS_CTRL, 32'h1);
      wr(OFS_REPEAT, 32'h2);
      wr(OFS_SCOUNT, 32'h3);
      wr(OFS_DIV, 32'h6);
      wr(OFS_THRESH, 32'h2);
      for (int i = 0; i < 3; i++) begin
         r[i] = 16'($random(seed));
         wr(OFS_DATA, {16'h0000, r[i]});
      end
      for (int i = 0; i < 6; i++) exp_dac.push_back(r[i % 3]);
      wr(OFS_CMD, 32'h1);
      wr(OFS_DATA, 32'h0);
      rd(OFS_FILL, 32'h3);
      wait_idle();
      rd(OFS_EVENT, 32'h1E);
      wr(OFS_EVENT, 32'h3F);
      wr(OFS_CMD, 32'h8);
      rd(OFS_FILL, 32'h0);
      rd(OFS_SAMPLES, 32'h0);
      rd(OFS_REPDONE, 32'h0);
      rd(OFS_STATUS, 32'h0);
      // FIFO, software stop, samples added while running
      wr(OFS_CTRL, 32'h40);
      wr(OFS_SCOUNT, 32'h100);
      wr(OFS_REPEAT, 32'h5);
      rd(OFS_REPEAT, 32'h2);
      load(2);
      wr(OFS_CMD, 32'h1);
      load(2);
      cyc(40);
      check(32'(o_operating), 32'h1);
      wr(OFS_CMD, 32'h2);
      wait_idle();
      rd(OFS_EVENT, 32'h10);
      // Overfill a running FIFO: flagged, output carries on
      load(1024);
      wr(OFS_CMD, 32'h1);
      wr(OFS_DATA, 32'h0);
      wr(OFS_DATA, 32'h0);
      cyc(30);
      check(32'(o_operating), 32'h1);
      rd(OFS_STATUS, 32'h11);
      wr(OFS_CMD, 32'h2);
      wait_idle();
      exp_dac.delete();
      wr(OFS_CMD, 32'h8);
      wr(OFS_EVENT, 32'h3F);
      // Trigger start, pin clock, then a too-short period
      wr(OFS_CTRL, 32'h4B);
      load(2);
      wr(OFS_CMD, 32'h1);
      cyc(8);
      rd(OFS_STATUS, 32'h3);
      cyc(0);
      far.pulse_trig();
      cyc(10);
      far.pulse_clk(12);
      far.pulse_clk(2);
      far.pulse_clk(2);
      wait_idle();
      rd(OFS_EVENT, 32'h31);
      rd(OFS_STATUS, 32'h8);
      wr(OFS_CMD, 32'hC);
      rd(OFS_STATUS, 32'h0);
      // FIFO, trigger stop: count reached first, then the pin edge
      wr(OFS_EVENT, 32'h3F);
      wr(OFS_CTRL, 32'h20);
      wr(OFS_SCOUNT, 32'h2);
      load(2);
      wr(OFS_CMD, 32'h1);
      cyc(30);
      rd(OFS_STATUS, 32'h5);
      cyc(0);
      far.pulse_trig();
      wait_idle();
      rd(OFS_EVENT, 32'h1E);
      cyc(4);
      report_and_stop();
   end
endmodule
`default_nettype wire
